// file: spi_peer.sv
// peripheral-side model of the serial link, mode 0, msb first
`timescale 1ns/100ps
module spi_peer
(
   input wire logic i_clk,
   input wire logic i_cs,
   input wire logic i_sclk,
   input wire logic i_simo,
   input wire logic [31:0] i_tx,
   output logic o_somi,
   output logic [31:0] o_rx,
   output logic [5:0] o_nbits,
   output logic [15:0] o_period
);
   logic [31:0] tx_sh; // outgoing stream, msb first
   int cyc = 0; // free-running clock count
   int last_rise = 0; // cycle of previous sampling edge
   initial
   begin
      o_somi = 1'b0;
   end
   // clock count, only used to time the serial clock
   always @(posedge i_clk) cyc++;
   // frame start: first bit out, counts cleared
   always @(negedge i_cs)
   begin
      tx_sh = i_tx;
      o_somi = i_tx[31];
      o_rx = 32'h0;
      o_nbits = 6'h00;
   end
   // leading edge samples what the controller drives, on its clock
   always @(posedge i_sclk)
   begin
      if (!i_cs)
      begin
         o_rx = {o_rx[30:0], i_simo};
         o_nbits = o_nbits + 6'h01;
         o_period = 16'(cyc - last_rise);
         last_rise = cyc;
      end
   end
   // trailing edge moves the next bit out
   always @(negedge i_sclk)
   begin
      if (!i_cs)
      begin
         tx_sh = tx_sh << 1;
         o_somi = tx_sh[31];
      end
   end
   // released line: inverse of last bit, so no stale value looks valid
   always @(posedge i_cs) o_somi = ~o_somi;
endmodule

// file: spi_port.sv
// multibuffer serial port: apb registers, buffer ram, transfer engine, pins
// Overview of operation
// - words of 2 to 16 bits, 16-bit shifter
// - bits shift in and out together
// - bit rate from clock, 8-bit divider
// - controller drives clock, peripheral follows it
// - each entry picks its own word format
// - unused port pins serve as gpio
// - buffer memory holds 256 entries
// - entry: transmit, receive, control, status words
// - entries split into sized transfer groups
// - finished word kept in receive buffer
// - period prescale+1 clocks, 2 at zero
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "spi_port_defs.svh"
module spi_port
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire spi_port_pkg::pins_t i_pin,
   output spi_port_pkg::pins_t o_pin,
   output spi_port_pkg::pins_t o_pin_oe
);
   import spi_port_pkg::*;

   // clamp a word length into the legal span
   function automatic logic [4:0] eff_len(input logic [4:0] l);
      if (l < `LEN_MIN)
         eff_len = `LEN_MIN;
      else if (l > `LEN_MAX)
         eff_len = `LEN_MAX;
      else
         eff_len = l;
   endfunction

   // serial clock period in clocks
   function automatic logic [8:0] period(input logic [7:0] p);
      period = (p == 8'h00) ? `PER_PS0 : {1'b0, p} + 9'h001;
   endfunction

   // buffer ram: {control, transmit} and {status, receive} per entry
   logic [31:0] mem_txc [256];
   logic [31:0] mem_rxs [256];

   // software state
   logic [7:0] ctrl_ff, nxt_ctrl; // enable, controller, pin functions
   fmt_t fmt_ff [`N_FMT];
   fmt_t nxt_fmt [`N_FMT];
   grp_t grp_ff [`N_GRP];
   grp_t nxt_grp [`N_GRP];
   logic [3:0] gdir_ff, nxt_gdir; // gpio direction
   logic [3:0] gout_ff, nxt_gout; // gpio level
   logic [15:0] rxbuf_ff, nxt_rxbuf; // last finished word
   logic full_ff, nxt_full;
   // engine state
   eng_state_t state_ff, nxt_state;
   logic [7:0] entry_ff, nxt_entry;
   logic [7:0] last_ff, nxt_last;
   logic [15:0] sh_ff, nxt_sh; // the one shift register
   logic [4:0] len_ff, nxt_len;
   logic [4:0] cnt_ff, nxt_cnt; // bits sampled so far
   logic cpol_ff, nxt_cpol;
   logic [8:0] per_ff, nxt_per;
   logic [8:0] div_ff, nxt_div;
   logic sclk_ff, nxt_sclk;
   logic bit_ff, nxt_bit; // bit being driven out
   // pins and bus answer
   pins_t s1_ff, s2_ff, s3_ff; // input synchroniser and edge stage
   pins_t pout_ff, nxt_pout;
   pins_t poe_ff, nxt_poe;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   // combinational helpers
   logic apb_acc, apb_done, wr, trig, mast;
   logic [7:0] idx;
   logic [31:0] rdat, txc, eng_data;
   logic err, eng_we, tog, lvl, lead, trail, in_bit;
   logic [8:0] half;
   logic [15:0] rxword;
   logic [3:0] fn;
   fmt_t fsel;
   pins_t fo, foe;

   // bus, register and engine next state
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      nxt_fmt = fmt_ff;
      nxt_grp = grp_ff;
      nxt_gdir = gdir_ff;
      nxt_gout = gout_ff;
      nxt_rxbuf = rxbuf_ff;
      nxt_full = full_ff;
      nxt_state = state_ff;
      nxt_entry = entry_ff;
      nxt_last = last_ff;
      nxt_sh = sh_ff;
      nxt_len = len_ff;
      nxt_cnt = cnt_ff;
      nxt_cpol = cpol_ff;
      nxt_per = per_ff;
      nxt_div = div_ff;
      nxt_sclk = sclk_ff;
      nxt_bit = bit_ff;
      nxt_prdata = prdata_ff;
      eng_we = 1'b0;
      mast = ctrl_ff[`C_MAST];
      idx = i_paddr[10:3];
      // one wait state so read data leaves a flip-flop
      apb_acc = i_psel & i_penable;
      apb_done = apb_acc & pready_ff;
      wr = apb_done & i_pwrite;
      nxt_pready = apb_acc & ~pready_ff;
      // read decode; unmapped or unaligned answers slverr
      rdat = 32'h0000_0000;
      err = (i_paddr[1:0] != 2'b00);
      if (i_paddr[`A_RAM_BIT])
         rdat = i_paddr[2] ? mem_rxs[idx] : mem_txc[idx];
      else
         case (i_paddr)
            `A_CTRL: rdat = {24'h00_0000, ctrl_ff};
            `A_TRIG: rdat = {23'h00_0000, entry_ff, state_ff != S_IDLE};
            `A_RXBUF: rdat = {15'h0000, full_ff, rxbuf_ff};
            `A_GDIR: rdat = {28'h000_0000, gdir_ff};
            `A_GOUT: rdat = {28'h000_0000, gout_ff};
            `A_GIN: rdat = {28'h000_0000, s2_ff};
            default:
            begin
               err = 1'b1;
               for (int n = 0; n < `N_FMT; n++)
                  if (i_paddr == `A_FMT0 + 12'(4 * n))
                  begin
                     rdat = {15'h0000, fmt_ff[n].cpol, fmt_ff[n].pre, 3'h0, fmt_ff[n].len};
                     err = 1'b0;
                  end
               for (int n = 0; n < `N_GRP; n++)
                  if (i_paddr == `A_GRP0 + 12'(4 * n))
                  begin
                     rdat = {16'h0000, grp_ff[n]};
                     err = 1'b0;
                  end
            end
         endcase
      if (nxt_pready)
         nxt_prdata = i_pwrite ? 32'h0000_0000 : rdat;
      nxt_pslverr = nxt_pready & err;
      // writes land at the edge that completes the access
      trig = 1'b0;
      if (wr && !err)
         case (i_paddr)
            `A_CTRL: nxt_ctrl = i_pwdata[7:0];
            `A_TRIG: trig = (state_ff == S_IDLE) & ctrl_ff[`C_EN]; // busy: ignored
            `A_GDIR: nxt_gdir = i_pwdata[3:0];
            `A_GOUT: nxt_gout = i_pwdata[3:0];
            default:
            begin
               for (int n = 0; n < `N_FMT; n++)
                  if (i_paddr == `A_FMT0 + 12'(4 * n))
                  begin
                     nxt_fmt[n].cpol = i_pwdata[`F_CPOL];
                     nxt_fmt[n].pre = i_pwdata[`F_PRE_LO +: 8];
                     nxt_fmt[n].len = i_pwdata[4:0];
                  end
               for (int n = 0; n < `N_GRP; n++)
                  if (i_paddr == `A_GRP0 + 12'(4 * n))
                     nxt_grp[n] = grp_t'(i_pwdata[15:0]);
            end
         endcase
      // reading the buffer clears full; a same-cycle capture wins below
      if (apb_done && !i_pwrite && i_paddr == `A_RXBUF)
         nxt_full = 1'b0;
      // edge source: own divider or synchronised pin clock
      txc = mem_txc[entry_ff];
      fsel = fmt_ff[txc[17:16]];
      half = (sclk_ff == cpol_ff) ? per_ff - {1'b0, per_ff[8:1]} : {1'b0, per_ff[8:1]};
      if (mast)
      begin
         tog = (div_ff == half - 9'h001);
         lvl = ~sclk_ff;
         in_bit = s2_ff.somi;
      end
      else
      begin
         tog = (s2_ff.clk != s3_ff.clk);
         lvl = s2_ff.clk;
         in_bit = s2_ff.simo;
      end
      lead = (state_ff == S_SHIFT) & tog & (lvl != cpol_ff);
      trail = (state_ff == S_SHIFT) & tog & (lvl == cpol_ff);
      rxword = {sh_ff[14:0], in_bit} & (16'hFFFF >> (5'h10 - len_ff));
      eng_data = {14'h0000, mem_rxs[entry_ff][`ST_DONE], 1'b1, rxword};
      unique case (state_ff)
         S_IDLE:
            if (trig)
            begin
               nxt_entry = grp_ff[i_pwdata[1:0]].first;
               nxt_last = grp_ff[i_pwdata[1:0]].last;
               nxt_state = S_LOAD;
            end
         S_LOAD:
         begin
            nxt_len = eff_len(fsel.len);
            nxt_cpol = fsel.cpol;
            nxt_per = period(fsel.pre);
            nxt_sh = txc[15:0];
            nxt_cnt = 5'h00;
            nxt_div = 9'h000;
            nxt_sclk = fsel.cpol;
            nxt_bit = txc[4'(nxt_len - 5'h01)];
            nxt_state = S_SHIFT;
         end
         S_SHIFT:
         begin
            if (mast)
            begin
               nxt_div = tog ? 9'h000 : div_ff + 9'h001;
               if (tog)
                  nxt_sclk = ~sclk_ff;
            end
            // sample in while the word shifts out
            if (lead)
            begin
               nxt_sh = {sh_ff[14:0], in_bit};
               nxt_cnt = cnt_ff + 5'h01;
               if (cnt_ff == len_ff - 5'h01)
               begin
                  eng_we = 1'b1;
                  nxt_rxbuf = rxword;
                  nxt_full = 1'b1;
               end
            end
            if (trail)
            begin
               if (cnt_ff == len_ff)
                  nxt_state = S_NEXT;
               else
                  nxt_bit = sh_ff[4'(len_ff - 5'h01)];
            end
         end
         S_NEXT:
            if (entry_ff == last_ff)
               nxt_state = S_IDLE;
            else
            begin
               nxt_entry = entry_ff + 8'h01;
               nxt_state = S_LOAD;
            end
      endcase
      // disabling aborts at once
      if (!ctrl_ff[`C_EN])
         nxt_state = S_IDLE;
      // pins: port function where enabled, else gpio
      fn = ctrl_ff[`C_EN] ? ctrl_ff[7:4] : 4'h0;
      fo = '{cs: nxt_state == S_IDLE, somi: nxt_bit, simo: nxt_bit, clk: nxt_sclk};
      foe = '{cs: mast, somi: ~mast, simo: mast, clk: mast};
      nxt_pout = pins_t'((4'(fo) & fn) | (gout_ff & ~fn));
      nxt_poe = pins_t'((4'(foe) & fn) | (gdir_ff & ~fn));
   end

   // register stage
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ctrl_ff <= `CTRL_RST;
         for (int n = 0; n < `N_FMT; n++)
            fmt_ff[n] <= fmt_t'(`FMT_RST);
         for (int n = 0; n < `N_GRP; n++)
            grp_ff[n] <= grp_t'(`GRP_RST);
         gdir_ff <= 4'h0;
         gout_ff <= 4'h0;
         rxbuf_ff <= 16'h0000;
         full_ff <= 1'b0;
         state_ff <= S_IDLE;
         entry_ff <= 8'h00;
         last_ff <= 8'h00;
         sh_ff <= 16'h0000;
         len_ff <= `LEN_MIN;
         cnt_ff <= 5'h00;
         cpol_ff <= 1'b0;
         per_ff <= `PER_PS0;
         div_ff <= 9'h000;
         sclk_ff <= 1'b0;
         bit_ff <= 1'b0;
         pout_ff <= '0;
         poe_ff <= '0;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         fmt_ff <= nxt_fmt;
         grp_ff <= nxt_grp;
         gdir_ff <= nxt_gdir;
         gout_ff <= nxt_gout;
         rxbuf_ff <= nxt_rxbuf;
         full_ff <= nxt_full;
         state_ff <= nxt_state;
         entry_ff <= nxt_entry;
         last_ff <= nxt_last;
         sh_ff <= nxt_sh;
         len_ff <= nxt_len;
         cnt_ff <= nxt_cnt;
         cpol_ff <= nxt_cpol;
         per_ff <= nxt_per;
         div_ff <= nxt_div;
         sclk_ff <= nxt_sclk;
         bit_ff <= nxt_bit;
         pout_ff <= nxt_pout;
         poe_ff <= nxt_poe;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // pin synchroniser; first stage feeds only the second
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end
      else
      begin
         s1_ff <= i_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // ram writes; engine status write last so its set wins
   always_ff @(posedge i_clk)
   begin
      if (wr && !err && i_paddr[`A_RAM_BIT] && !i_paddr[2])
         mem_txc[idx] <= i_pwdata;
      if (wr && !err && i_paddr[`A_RAM_BIT] && i_paddr[2])
         mem_rxs[idx] <= i_pwdata;
      if (eng_we)
         mem_rxs[entry_ff] <= eng_data;
   end

   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_pin = pout_ff;
   assign o_pin_oe = poe_ff;

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_last_lead;
      lead && cnt_ff == len_ff - 5'h01;
   endsequence
   sequence s_entry_end;
      state_ff == S_NEXT && entry_ff == last_ff;
   endsequence

   a_len_range: assert property (state_ff == S_SHIFT |->
      len_ff >= `LEN_MIN && len_ff <= `LEN_MAX) else $error("word length out of span");
   a_full_duplex: assert property (lead |=>
      sh_ff == {$past(sh_ff[14:0]), $past(in_bit)}) else $error("sample not shifted in");
   a_div_bound: assert property (state_ff == S_SHIFT && mast |->
      div_ff < per_ff) else $error("divider overran period");
   a_ctrl_clock: assert property (ctrl_ff[`C_EN] && ctrl_ff[4] |=>
      o_pin_oe.clk == $past(mast)) else $error("clock pin direction wrong");
   a_format_pick: assert property (state_ff == S_LOAD |=>
      len_ff == eff_len($past(fsel.len)) && cpol_ff == $past(fsel.cpol))
      else $error("entry format not applied");
   a_gpio_pin: assert property (1'b1 |=>
      ((4'(o_pin) ^ $past(gout_ff)) & ~$past(fn)) == 4'h0) else $error("gpio level lost");
   a_ram_write: assert property (wr && !err && i_paddr[`A_RAM_BIT] && !i_paddr[2] |=>
      mem_txc[$past(idx)] == $past(i_pwdata)) else $error("entry write lost");
   a_group_end: assert property (s_entry_end |=> state_ff == S_IDLE)
      else $error("group ran past its end");
   a_rx_capture: assert property (s_last_lead |=>
      full_ff && rxbuf_ff == $past(rxword)) else $error("word not captured");
   a_prescale: assert property (state_ff == S_LOAD |=>
      per_ff == period($past(fsel.pre))) else $error("bad clock period");
   a_apb_wait: assert property (apb_acc && !pready_ff |=> o_pready ##1 !o_pready)
      else $error("ready not one cycle");
endmodule

// file: spi_port_defs.svh
// register map, field positions, reset values and limits of the serial port
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH
`define A_CTRL 12'h000
`define A_FMT0 12'h004
`define A_GRP0 12'h014
`define A_TRIG 12'h024
`define A_RXBUF 12'h028
`define A_GDIR 12'h02C
`define A_GOUT 12'h030
`define A_GIN 12'h034
`define A_RAM_BIT 11
`define C_EN 0
`define C_MAST 1
`define F_PRE_LO 8
`define F_CPOL 16
`define ST_DONE 16
`define ST_OVR 17
`define N_FMT 4
`define N_GRP 4
`define CTRL_RST 8'h00
`define FMT_RST 14'h0108
`define GRP_RST 16'hFF00
`define LEN_MIN 5'h02
`define LEN_MAX 5'h10
`define PER_PS0 9'h002
`endif

// file: spi_port_pkg.sv
// types shared by the multibuffer serial port
package spi_port_pkg;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_LOAD = 2'b01,
      S_SHIFT = 2'b10,
      S_NEXT = 2'b11
   } eng_state_t;
   typedef struct packed {
      logic cpol;
      logic [7:0] pre;
      logic [4:0] len;
   } fmt_t;
   typedef struct packed {
      logic [7:0] last;
      logic [7:0] first;
   } grp_t;
   typedef struct packed {
      logic cs;
      logic somi;
      logic simo;
      logic clk;
   } pins_t;
endpackage

// file: test_multibuffer_serial_port.sv
// self-checking bench: apb registers, gpio, grouped controller transfers
`timescale 1ns/100ps
`include "spi_port_defs.svh"
module test_multibuffer_serial_port;
   import spi_port_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0;
   logic [31:0] o_prdata;
   logic o_pready;
   logic o_pslverr;
   pins_t o_pin;
   pins_t o_pin_oe;
   pins_t pin_lvl; // resolved wire levels
   logic [3:0] ext = 4'hF; // far-side levels on undriven pins
   logic gp = 1'b1; // pins used as gpio
   logic p_somi;
   logic [31:0] ptx = 32'h0; // peer outgoing stream
   logic [31:0] p_rx;
   logic [5:0] p_nbits;
   logic [15:0] p_period;
   logic [31:0] rdat; // last read data
   logic rerr; // last error flag
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   // wire level: driver wins, else the far side
   assign pin_lvl = pins_t'((o_pin & o_pin_oe)
      | (~o_pin_oe & (gp ? ext : {ext[3], p_somi, ext[1:0]})));
   spi_port u_spi_port (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pin(pin_lvl),
      .o_pin(o_pin), .o_pin_oe(o_pin_oe));
   spi_peer u_spi_peer (.i_clk(i_clk), .i_cs(pin_lvl.cs), .i_sclk(pin_lvl.clk),
      .i_simo(pin_lvl.simo), .i_tx(ptx), .o_somi(p_somi), .o_rx(p_rx), .o_nbits(p_nbits),
      .o_period(p_period));
   // 40 MHz clock
   always #12.5 i_clk = ~i_clk;
   // run limit, well above the expected length
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end
   // low mask of l bits
   function automatic logic [31:0] msk(input int l);
      return (32'h1 << l) - 32'h1;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1); // only the run limit ends a stuck access
      rdat = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e & m, rdat & m);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      int k, l0, l1, p0, p1, n;
      logic [15:0] tx0, tx1;
      logic [31:0] r0, r1;
      void'($urandom(32'h796D));
      repeat (12) @(posedge i_clk);
      i_reset <= 1'b0; // released after 12 clocks held in reset
      @(posedge i_clk);
      // reset values and a bad address
      rchk("ctrl", `A_CTRL, 32'hFFFF_FFFF, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         rchk("fmt", 12'(`A_FMT0 + 4 * i), 32'h0001_FF1F, 32'h0000_0808);
         rchk("grp", 12'(`A_GRP0 + 4 * i), 32'h0000_FFFF, 32'h0000_FF00);
      end
      apb(1'b0, 12'h038, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, rerr});
      // idle port pins as gpio
      k = $urandom_range(0, 15);
      apb(1'b1, `A_GDIR, 32'hF);
      apb(1'b1, `A_GOUT, 32'(k));
      @(posedge i_clk);
      chk("gpio out", 32'(k), {28'h0, o_pin});
      chk("gpio oe", 32'hF, {28'h0, o_pin_oe});
      apb(1'b1, `A_GDIR, 32'h0);
      ext <= 4'($urandom);
      repeat (4) @(posedge i_clk);
      rchk("gpio in", `A_GIN, 32'hF, {28'h0, ext});
      // controller mode, all four pins on the port
      gp <= 1'b0;
      ext <= 4'hF;
      apb(1'b1, `A_CTRL, 32'h0000_00F3);
      for (int t = 0; t < 3; t++)
      begin
         k = (t == 0) ? 254 : $urandom_range(0, 253);
         l0 = (t == 0) ? 16 : $urandom_range(2, 16);
         l1 = (t == 0) ? 2 : $urandom_range(2, 16);
         // receive needs three low cycles per bit through the synchroniser
         p0 = $urandom_range(4, 8);
         p1 = (t == 2) ? 0 : $urandom_range(4, 8);
         tx0 = 16'($urandom);
         tx1 = 16'($urandom);
         ptx = $urandom;
         apb(1'b1, 12'(`A_FMT0 + 4 * t), 32'((p0 << 8) | l0));
         apb(1'b1, 12'(`A_FMT0 + 4 * (t + 1)), 32'((p1 << 8) | l1));
         apb(1'b1, 12'(`A_GRP0 + 4 * t), 32'(((k + 1) << 8) | k));
         apb(1'b1, 12'(12'h800 + 8 * k), {14'h0, 2'(t), tx0});
         apb(1'b1, 12'(12'h808 + 8 * k), {14'h0, 2'(t + 1), tx1});
         rchk("entry tx", 12'(12'h800 + 8 * k), 32'h0003_FFFF, {14'h0, 2'(t), tx0});
         apb(1'b1, `A_TRIG, 32'(t));
         n = 0;
         do
         begin
            apb(1'b0, `A_TRIG, 32'h0);
            n++;
         end while (rdat[0] !== 1'b0); // a hang runs into the run limit
         r0 = (ptx >> (32 - l0)) & msk(l0);
         r1 = (ptx >> (32 - l0 - l1)) & msk(l1);
         chk("peer rx", ((32'(tx0) & msk(l0)) << l1) | (32'(tx1) & msk(l1)), p_rx);
         chk("peer bits", 32'(l0 + l1), {26'h0, p_nbits});
         chk("period", (p1 == 0) ? 32'd2 : 32'(p1 + 1), {16'h0, p_period});
         rchk("entry0 rx", 12'(12'h804 + 8 * k), 32'h0001_FFFF, {15'h0, 1'b1, r0[15:0]});
         // full rate is too fast for reliable receive, so only flags there
         n = (p1 == 0) ? 32'h0001_0000 : 32'h0001_FFFF;
         rchk("entry1 rx", 12'(12'h80C + 8 * k), n, {15'h0, 1'b1, r1[15:0]});
         rchk("rxbuf", `A_RXBUF, n, {15'h0, 1'b1, r1[15:0]});
         rchk("rxbuf clear", `A_RXBUF, 32'h0001_0000, 32'h0);
      end
      // peripheral mode: bench drives clock and simo, port answers on somi
      l0 = $urandom_range(2, 16);
      tx0 = 16'($urandom);
      tx1 = 16'($urandom);
      apb(1'b1, `A_FMT0, 32'(l0));
      apb(1'b1, `A_GRP0, 32'h0);
      apb(1'b1, 12'h800, {16'h0, tx0});
      ext <= 4'h8;
      apb(1'b1, `A_CTRL, 32'h0000_00F1);
      apb(1'b1, `A_TRIG, 32'h0);
      r0 = 32'h0;
      for (int i = 0; i < l0; i++)
      begin
         // simo set in the low phase, well before the rising edge
         ext <= {2'b10, tx1[l0 - 1 - i], 1'b0};
         repeat (6) @(posedge i_clk);
         r0 = {r0[30:0], o_pin.somi};
         ext[0] <= 1'b1;
         repeat (6) @(posedge i_clk);
      end
      ext[0] <= 1'b0;
      repeat (8) @(posedge i_clk);
      chk("peri somi", 32'(tx0) & msk(l0), r0);
      rchk("peri rxbuf", `A_RXBUF, 32'h0001_FFFF, {15'h0, 1'b1, tx1 & 16'(msk(l0))});
      end_of_test();
   end
endmodule
